/* File: verilog/cbm_exec_unit.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Rotate right via carry, sets Z C N V
// - Copy register bit into T, one cycle
// - Copy T into register bit, flags kept
// - Half carry set or clear, only H
// - Sign test set or clear, only S
// - Overflow set or clear, only V
// - Indirect read then pointer plus one
// - Pointer minus one then indirect read
// - Read at pointer plus q, pointer kept
// - Indirect write then pointer plus one
// - Pointer minus one then indirect write
// - Write at pointer plus q, pointer kept
// - Direct read at k, two cycles
// - Direct write at k, two cycles
// - Program fetch at Z, three cycles
// - Push and pop in two cycles
module cbm_exec_unit
  import cbm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Command
  input  wire logic        cmdValid,
  input  wire cbm_cmd_t    cmd,
  output logic             cmdReady,
  output logic             done,
  // Processor flags and stack
  output logic      [7:0]  procFlags,
  output logic      [15:0] stackPtr,
  // Data memory
  output logic      [15:0] dmAddr,
  output logic      [7:0]  dmWdata,
  output logic             dmWe,
  output logic             dmRe,
  input  wire logic [7:0]  dmRdata,
  // Program memory
  output logic      [15:0] pmAddr,
  output logic             pmRe,
  input  wire logic [7:0]  pmRdata
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_MEM  = 3'b010,
    ST_PM1  = 3'b011,
    ST_PM2  = 3'b100
  } cbm_state_t;

  cbm_state_t  state_r;
  cbm_state_t  state_nxt;
  cbm_cmd_t    cmd_r;
  logic [7:0]  flags_r;
  logic [15:0] sp_r;
  logic [15:0] dmAddr_r;
  logic [7:0]  dmWdata_r;
  logic        dmWe_r;
  logic        dmRe_r;
  logic [15:0] pmAddr_r;
  logic        pmRe_r;
  logic        done_r;
  logic        ready_r;
  logic [7:0]  opA;
  logic [7:0]  opB;
  logic [15:0] ptrVal;
  logic [7:0]  bitResult;
  logic [7:0]  bitFlags;
  logic        isBitOp;
  logic        isRead;
  logic        isWrite;
  logic [15:0] effAddr;
  logic        ptrUpd;
  logic [15:0] ptrNew;
  logic        wrEn;
  logic [7:0]  wrData;
  logic        accept;

  // ----------------------------------------------------------------
  // Operand fetch and bit unit
  // ----------------------------------------------------------------
  assign accept = cmdValid && ready_r;

  // Operands come out of the register file one cycle after accept
  cbm_reg_file uRegs (
    .clk       (clk),
    .rst_b     (rst_b),
    .rdAddrA   (cmd.rd),
    .rdAddrB   (cmd.rr),
    .rdAddrP   (PTR_BASE + {(cmd.op == OP_PROG_FETCH) ? PS_Z : cmd.ptrSel, 1'b0}),
    .rdDataA   (opA),
    .rdDataB   (opB),
    .rdDataP   (ptrVal),
    .wrEn      (wrEn),
    .wrAddr    (cmd_r.rd),
    .wrData    (wrData),
    .ptrWrEn   (ptrUpd),
    .ptrWrAddr (PTR_BASE + {(cmd_r.op == OP_PROG_FETCH) ? PS_Z : cmd_r.ptrSel, 1'b0}),
    .ptrWrData (ptrNew)
  );

  cbm_bit_unit uBits (
    .op       (cmd_r.op),
    .bitSel   (cmd_r.bitSel),
    .flagVal  (cmd_r.flagVal),
    .opA      (opA),
    .opB      (opB),
    .flagsIn  (flags_r),
    .result   (bitResult),
    .flagsOut (bitFlags)
  );

  // ----------------------------------------------------------------
  // Operation classes
  // ----------------------------------------------------------------
  assign isBitOp = cmd_r.op inside {OP_ROTATE_RIGHT, OP_BIT_TO_T, OP_T_TO_BIT, OP_FLAG_WRITE};
  assign isRead  = cmd_r.op inside {OP_READ_IND, OP_READ_DISP, OP_READ_DIR, OP_POP};
  assign isWrite = cmd_r.op inside {OP_WRITE_IND, OP_WRITE_DISP, OP_WRITE_DIR, OP_PUSH};

  // ----------------------------------------------------------------
  // Address generation and pointer update
  // ----------------------------------------------------------------
  always_comb begin
    effAddr = ptrVal;
    ptrNew  = ptrVal;
    ptrUpd  = 1'b0;
    unique case (cmd_r.op)
      OP_READ_IND, OP_WRITE_IND: begin
        if (cmd_r.ptrMode == PM_PREDEC) begin
          effAddr = ptrVal - 16'h0001;
          ptrNew  = ptrVal - 16'h0001;
          ptrUpd  = (state_r == ST_EXEC);
        end else if (cmd_r.ptrMode == PM_POSTINC) begin
          ptrNew  = ptrVal + 16'h0001;
          ptrUpd  = (state_r == ST_EXEC);
        end
      end
      OP_READ_DISP, OP_WRITE_DISP: effAddr = ptrVal + {10'h000, cmd_r.disp};
      OP_READ_DIR, OP_WRITE_DIR:   effAddr = cmd_r.kAddr;
      // push writes at SP, pop reads above it
      OP_PUSH:                     effAddr = sp_r;
      OP_POP:                      effAddr = sp_r + 16'h0001;
      OP_PROG_FETCH: begin
        // Z advances after the fetch when asked
        ptrNew = ptrVal + 16'h0001;
        ptrUpd = (state_r == ST_EXEC) && (cmd_r.ptrMode == PM_POSTINC);
      end
      default: begin
        effAddr = ptrVal;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Register file write data
  // ----------------------------------------------------------------
  // Loads land at the end of their last cycle, bit ops in the execute cycle
  always_comb begin
    wrEn   = 1'b0;
    wrData = bitResult;
    if (state_r == ST_EXEC && cmd_r.op inside {OP_ROTATE_RIGHT, OP_T_TO_BIT}) begin
      wrEn = 1'b1;
    end else if (state_r == ST_MEM && isRead) begin
      wrEn   = 1'b1;
      wrData = dmRdata;
    end else if (state_r == ST_PM2) begin
      wrEn   = 1'b1;
      wrData = pmRdata;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (accept) state_nxt = ST_EXEC;
      ST_EXEC: begin
        if (cmd_r.op == OP_PROG_FETCH) begin
          state_nxt = ST_PM1;
        end else if (isRead || isWrite) begin
          state_nxt = ST_MEM;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_MEM:  state_nxt = ST_IDLE;
      ST_PM1:  state_nxt = ST_PM2;
      ST_PM2:  state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Command held for the whole operation
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r <= '0;
    end else if (accept) begin
      cmd_r <= cmd;
    end
  end

  // Handshake: one operation in flight, so no hazard on the register file
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_r <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      ready_r <= (state_nxt == ST_IDLE);
      done_r  <= (state_r != ST_IDLE) && (state_nxt == ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Processor flags
  // ----------------------------------------------------------------
  // flags from the bit unit, on every bit operation
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r <= FLAGS_RESET;
    end else if (state_r == ST_EXEC && isBitOp) begin
      flags_r <= bitFlags;
    end
  end

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------
  // push decrements, pop increments
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_r <= SP_RESET;
    end else if (state_r == ST_EXEC && cmd_r.op == OP_PUSH) begin
      sp_r <= sp_r - 16'h0001;
    end else if (state_r == ST_EXEC && cmd_r.op == OP_POP) begin
      sp_r <= sp_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Memory strobes, held for one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dmAddr_r  <= 16'h0000;
      dmWdata_r <= 8'h00;
      dmWe_r    <= 1'b0;
      dmRe_r    <= 1'b0;
    end else begin
      dmWe_r <= (state_r == ST_EXEC) && isWrite;
      dmRe_r <= (state_r == ST_EXEC) && isRead;
      if (state_r == ST_EXEC && (isRead || isWrite)) begin
        dmAddr_r  <= effAddr;
        dmWdata_r <= opB;
      end
    end
  end

  // Program memory answers one cycle after its strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pmAddr_r <= 16'h0000;
      pmRe_r   <= 1'b0;
    end else begin
      pmRe_r <= (state_r == ST_EXEC) && (cmd_r.op == OP_PROG_FETCH);
      if (state_r == ST_EXEC && cmd_r.op == OP_PROG_FETCH) begin
        pmAddr_r <= ptrVal;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmdReady  = ready_r;
  assign done      = done_r;
  assign procFlags = flags_r;
  assign stackPtr  = sp_r;
  assign dmAddr    = dmAddr_r;
  assign dmWdata   = dmWdata_r;
  assign dmWe      = dmWe_r;
  assign dmRe      = dmRe_r;
  assign pmAddr    = pmAddr_r;
  assign pmRe      = pmRe_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [1:0] busyCnt_r;
  logic       inExec;
  assign inExec = (state_r == ST_EXEC);

  // Cycles spent since the execute cycle began
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busyCnt_r <= 2'h0;
    end else if (state_r == ST_IDLE) begin
      busyCnt_r <= 2'h0;
    end else begin
      busyCnt_r <= busyCnt_r + 2'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_ROR_RESULT: assert property (inExec && cmd_r.op == OP_ROTATE_RIGHT |->
    wrEn && wrData == {flags_r[FLAG_C], opA[7:1]} ##1 done && procFlags[FLAG_C] == $past(opA[0], 1))
    else $error("rotate result or carry wrong");
  AST_BIT_OP_LEN: assert property (done && isBitOp |-> busyCnt_r == CYC_BIT_OP)
    else $error("bit operation not one cycle");
  AST_BIT_TO_T: assert property (inExec && cmd_r.op == OP_BIT_TO_T |=>
    procFlags == (($past(procFlags) & ~(8'h01 << FLAG_T)) | ({7'h00, $past(opB[cmd_r.bitSel])} << FLAG_T)))
    else $error("T copy wrong or other flag moved");
  AST_T_TO_BIT: assert property (inExec && cmd_r.op == OP_T_TO_BIT |->
    wrEn && wrData[cmd_r.bitSel] == procFlags[FLAG_T] ##1 $stable(procFlags))
    else $error("bit load wrong or flags moved");
  AST_FLAG_FORCE: assert property (inExec && cmd_r.op == OP_FLAG_WRITE |=>
    procFlags[$past(cmd_r.bitSel)] == $past(cmd_r.flagVal)
    && (procFlags ^ $past(procFlags)) == ((procFlags ^ $past(procFlags)) & (8'h01 << $past(cmd_r.bitSel))))
    else $error("flag write wrong or touched another flag");
  AST_POSTINC_READ: assert property (inExec && cmd_r.op == OP_READ_IND && cmd_r.ptrMode == PM_POSTINC |->
    ptrUpd && ptrNew == ptrVal + 16'h0001 ##1 dmRe && dmAddr == $past(ptrVal))
    else $error("post-increment read wrong");
  AST_PREDEC_ADDR: assert property (inExec && cmd_r.ptrMode == PM_PREDEC
    && cmd_r.op inside {OP_READ_IND, OP_WRITE_IND} |=> dmAddr == $past(ptrVal) - 16'h0001)
    else $error("pre-decrement address wrong");
  AST_DISP_KEEP: assert property (inExec && cmd_r.op inside {OP_READ_DISP, OP_WRITE_DISP} |->
    !ptrUpd ##1 dmAddr == $past(ptrVal) + {10'h000, $past(cmd_r.disp)})
    else $error("displaced access wrong");
  AST_WRITE_SEQ: assert property (inExec && isWrite |=> dmWe && dmWdata == $past(opB)
    ##1 done && !dmWe)
    else $error("write strobe or data wrong");
  AST_DATA_LEN: assert property (done && (isRead || isWrite) |-> busyCnt_r == CYC_DATA
    && $stable(procFlags))
    else $error("data access not two cycles");
  AST_PROG_FETCH: assert property (inExec && cmd_r.op == OP_PROG_FETCH |=> pmRe && pmAddr == $past(ptrVal)
    ##1 !done ##1 done && busyCnt_r == CYC_PROG)
    else $error("program fetch timing wrong");
  AST_STACK_MOVE: assert property (inExec && cmd_r.op inside {OP_PUSH, OP_POP} |=>
    stackPtr == (($past(cmd_r.op) == OP_PUSH) ? $past(stackPtr) - 16'h0001 : $past(stackPtr) + 16'h0001))
    else $error("stack pointer step wrong");

  COV_ROTATE: cover property (inExec && cmd_r.op == OP_ROTATE_RIGHT ##1 done);
  COV_FETCH_INC: cover property (inExec && cmd_r.op == OP_PROG_FETCH && cmd_r.ptrMode == PM_POSTINC);
  COV_POP: cover property (inExec && cmd_r.op == OP_POP ##2 done);

endmodule // cbm_exec_unit

/* File: inc/cbm_pkg.sv */
package cbm_pkg;

  // ----------------------------------------------------------------
  // Register file and flag layout
  // ----------------------------------------------------------------
  localparam int          REG_COUNT   = 32;
  localparam logic [4:0]  PTR_BASE    = 5'h1A;   // First byte of the X pair
  localparam int          FLAG_C      = 0;
  localparam int          FLAG_Z      = 1;
  localparam int          FLAG_N      = 2;
  localparam int          FLAG_V      = 3;
  localparam int          FLAG_S      = 4;
  localparam int          FLAG_H      = 5;
  localparam int          FLAG_T      = 6;
  localparam int          FLAG_I      = 7;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [15:0] SP_RESET    = 16'h00FF;

  // ----------------------------------------------------------------
  // Execution lengths in clock cycles, counted from the execute cycle
  // ----------------------------------------------------------------
  localparam logic [1:0]  CYC_BIT_OP  = 2'h1;
  localparam logic [1:0]  CYC_DATA    = 2'h2;
  localparam logic [1:0]  CYC_PROG    = 2'h3;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP          = 4'h0,
    OP_ROTATE_RIGHT = 4'h1,  // rotate_right_via_carry
    OP_BIT_TO_T     = 4'h2,  // copy_bit_to_transfer_flag
    OP_T_TO_BIT     = 4'h3,  // copy_transfer_flag_to_bit
    OP_FLAG_WRITE   = 4'h4,  // half_carry_on/off, sign_test_on/off, overflow_on/off
    OP_READ_IND     = 4'h5,  // memory_read_indirect
    OP_WRITE_IND    = 4'h6,  // memory_write_indirect
    OP_READ_DISP    = 4'h7,  // memory_read_displaced
    OP_WRITE_DISP   = 4'h8,  // memory_write_displaced
    OP_READ_DIR     = 4'h9,  // memory_read_direct
    OP_WRITE_DIR    = 4'hA,  // memory_write_direct
    OP_PROG_FETCH   = 4'hB,  // program_word_fetch
    OP_PUSH         = 4'hC,
    OP_POP          = 4'hD
  } cbm_op_t;

  typedef enum logic [1:0] {
    PM_PLAIN   = 2'h0,
    PM_POSTINC = 2'h1,
    PM_PREDEC  = 2'h2
  } cbm_ptr_mode_t;

  typedef enum logic [1:0] {
    PS_X = 2'h0,
    PS_Y = 2'h1,
    PS_Z = 2'h2
  } cbm_ptr_sel_t;

  typedef struct packed {
    cbm_op_t       op;
    logic [4:0]    rd;       // Destination register
    logic [4:0]    rr;       // Source register
    logic [2:0]    bitSel;   // Bit number, or flag number for flag writes
    logic          flagVal;  // Value forced by a flag write
    cbm_ptr_sel_t  ptrSel;
    cbm_ptr_mode_t ptrMode;
    logic [5:0]    disp;     // Displacement q
    logic [15:0]   kAddr;    // Direct address k
  } cbm_cmd_t;

endpackage

/* File: verilog/cbm_reg_file.sv */
`timescale 1ns/1ps
module cbm_reg_file
  import cbm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Read ports, data registered
  input  wire logic [4:0]  rdAddrA,
  input  wire logic [4:0]  rdAddrB,
  input  wire logic [4:0]  rdAddrP,
  output logic      [7:0]  rdDataA,
  output logic      [7:0]  rdDataB,
  output logic      [15:0] rdDataP,
  // Byte write port
  input  wire logic        wrEn,
  input  wire logic [4:0]  wrAddr,
  input  wire logic [7:0]  wrData,
  // Pointer pair write port
  input  wire logic        ptrWrEn,
  input  wire logic [4:0]  ptrWrAddr,
  input  wire logic [15:0] ptrWrData
);

  logic [7:0] mem [REG_COUNT];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Byte write wins over pair write when both hit one entry
  for (genvar g = 0; g < REG_COUNT; g++) begin : gEntry
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        mem[g] <= 8'h00;
      end else if (wrEn && wrAddr == 5'(g)) begin
        mem[g] <= wrData;
      end else if (ptrWrEn && ptrWrAddr == 5'(g)) begin
        mem[g] <= ptrWrData[7:0];
      end else if (ptrWrEn && (ptrWrAddr + 5'h01) == 5'(g)) begin
        mem[g] <= ptrWrData[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdDataA <= 8'h00;
      rdDataB <= 8'h00;
      rdDataP <= 16'h0000;
    end else begin
      rdDataA <= mem[rdAddrA];
      rdDataB <= mem[rdAddrB];
      rdDataP <= {mem[rdAddrP + 5'h01], mem[rdAddrP]};
    end
  end

endmodule // cbm_reg_file

/* File: verilog/cbm_bit_unit.sv */
`timescale 1ns/1ps
module cbm_bit_unit
  import cbm_pkg::*;
(
  // Operation
  input  wire cbm_op_t     op,
  input  wire logic [2:0]  bitSel,
  input  wire logic        flagVal,
  // Operands
  input  wire logic [7:0]  opA,
  input  wire logic [7:0]  opB,
  input  wire logic [7:0]  flagsIn,
  // Results
  output logic      [7:0]  result,
  output logic      [7:0]  flagsOut
);

  // ----------------------------------------------------------------
  // Rotate, bit transfer and single flag writes
  // ----------------------------------------------------------------
  always_comb begin
    result   = opA;
    flagsOut = flagsIn;
    unique case (op)
      OP_ROTATE_RIGHT: begin
        result           = {flagsIn[FLAG_C], opA[7:1]};
        flagsOut[FLAG_C] = opA[0];
        flagsOut[FLAG_Z] = (result == 8'h00);
        flagsOut[FLAG_N] = result[7];
        flagsOut[FLAG_V] = result[7] ^ opA[0];  // N xor C after the shift
      end
      OP_BIT_TO_T:   flagsOut[FLAG_T] = opB[bitSel];
      OP_T_TO_BIT:   result[bitSel] = flagsIn[FLAG_T];
      OP_FLAG_WRITE: flagsOut[bitSel] = flagVal;
      default: begin
        result   = opA;
        flagsOut = flagsIn;
      end
    endcase
  end

endmodule // cbm_bit_unit

/* File: verif/cbm_mem.sv */
`timescale 1ns/1ps
module cbm_mem (
  // Clock
  input  wire logic        clk,
  // Data memory
  input  wire logic [15:0] dmAddr,
  input  wire logic [7:0]  dmWdata,
  input  wire logic        dmWe,
  input  wire logic        dmRe,
  output logic      [7:0]  dmRdata,
  // Program memory
  input  wire logic [15:0] pmAddr,
  input  wire logic        pmRe,
  output logic      [7:0]  pmRdata
);
  // Only 256 bytes each, upper address bits ignored
  logic [7:0] dataMem [256];
  logic [7:0] progMem [256];
  logic [7:0] pmByte;
  logic       pmValid;
  // Known fill, so an untouched byte never reads unknown
  initial begin
    pmValid = 1'b0;
    pmByte = 8'h00;
    for (int i = 0; i < 256; i++) begin
      dataMem[i] = 8'(i * 7 + 3);
      progMem[i] = 8'(i * 5 + 1);
    end
  end
  // Unstrobed reads show inverted junk, not a stale byte
  assign dmRdata = dmRe ? dataMem[dmAddr[7:0]] : ~dataMem[dmAddr[7:0]];
  // Writes land at the strobed edge
  always @(posedge clk) begin
    if (dmWe) begin
      dataMem[dmAddr[7:0]] <= dmWdata;
    end
  end
  // Program byte is valid only the cycle after its strobe
  always @(posedge clk) begin
    pmValid <= pmRe;
    pmByte  <= progMem[pmAddr[7:0]];
  end
  assign pmRdata = pmValid ? pmByte : ~pmByte;
endmodule // cbm_mem

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import cbm_pkg::*;
;
  // ------
  // Wiring
  // ------
  logic        clk;
  logic        rst_b;
  logic        cmdValid;
  cbm_cmd_t    cmd;
  logic        cmdReady;
  logic        done;
  logic [7:0]  procFlags;
  logic [15:0] stackPtr;
  logic [15:0] dmAddr;
  logic [7:0]  dmWdata;
  logic        dmWe;
  logic        dmRe;
  logic [7:0]  dmRdata;
  logic [15:0] pmAddr;
  logic        pmRe;
  logic [7:0]  pmRdata;
  logic [7:0]  expF;
  int          miscompares;
  int          checksDone;
  // 20 MHz clock
  initial clk = 1'b0;
  always #25 clk = ~clk;
  cbm_exec_unit cbm_exec_unit_inst (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady),
    .done(done), .procFlags(procFlags), .stackPtr(stackPtr), .dmAddr(dmAddr), .dmWdata(dmWdata), .dmWe(dmWe),
    .dmRe(dmRe), .dmRdata(dmRdata), .pmAddr(pmAddr), .pmRe(pmRe), .pmRdata(pmRdata));
  cbm_mem cbm_mem_inst (.clk(clk), .dmAddr(dmAddr), .dmWdata(dmWdata), .dmWe(dmWe), .dmRe(dmRe), .dmRdata(dmRdata),
    .pmAddr(pmAddr), .pmRe(pmRe), .pmRdata(pmRdata));
  // -------
  // Helpers
  // -------
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Offer a command, count cycles from acceptance to done; a hang ends the run
  task automatic run(input cbm_cmd_t c, input logic [1:0] cyc);
    int n;
    n = 0;
    cmd = c;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1 && n < 20) begin
      @(posedge clk) #1;
      n++;
    end
    if (n >= 20) begin
      miscompares++;
      $display("BAD at %0t: never ready", $time);
      end_of_test();
    end
    @(posedge clk) #1;
    cmdValid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk) #1;
      n++;
    end
    if (n >= 20) begin
      miscompares++;
      $display("BAD at %0t: no completion", $time);
      end_of_test();
    end
    check(8'(n), {6'h0, cyc});
  endtask
  function automatic cbm_cmd_t mk(cbm_op_t op, logic [4:0] r, logic [2:0] b = 3'h0, logic fv = 1'b0,
      int ps = 0, int pm = 0, logic [5:0] q = 6'h0, logic [15:0] k = 16'h0, int src = -1);
    return '{op, r, (src < 0) ? r : 5'(src), b, fv, cbm_ptr_sel_t'(2'(ps)), cbm_ptr_mode_t'(2'(pm)), q, k};
  endfunction
  function automatic logic [7:0] at(input logic [7:0] a);
    return cbm_mem_inst.dataMem[a];
  endfunction
  // Registers are loaded and seen through scratch bytes, by direct access
  task automatic poke(input int r, input logic [7:0] v);
    cbm_mem_inst.dataMem[8'hE0] = v;
    run(mk(OP_READ_DIR, 5'(r), .k(16'h00E0)), CYC_DATA);
  endtask
  task automatic peek(input int r, input logic [7:0] v);
    run(mk(OP_WRITE_DIR, 5'(r), .k(16'h00F0)), CYC_DATA);
    check(at(8'hF0), v);
  endtask
  // Pointer pair, low byte at the even register
  task automatic set_ptr(input int s, input logic [15:0] v);
    poke(PTR_BASE + 2 * s, v[7:0]);
    poke(PTR_BASE + 2 * s + 1, v[15:8]);
  endtask
  task automatic peek_ptr(input int s, input logic [15:0] v);
    peek(PTR_BASE + 2 * s, v[7:0]);
    peek(PTR_BASE + 2 * s + 1, v[15:8]);
  endtask
  // ---------
  // Scenarios
  // ---------
  // Rotate to zero, then carry comes back into bit 7
  task automatic t_rotate();
    logic [7:0] v;
    logic [7:0] n;
    v = 8'h01;
    poke(16, v);
    for (int i = 0; i < 2; i++) begin
      n = {expF[FLAG_C], v[7:1]};
      run(mk(OP_ROTATE_RIGHT, 5'h10), CYC_BIT_OP);
      expF[3:0] = {n[7] ^ v[0], n[7], n == 8'h00, v[0]};
      check(procFlags, expF);
      v = n;
    end
    peek(16, v);
  endtask
  // Bit into T and back, set then cleared
  task automatic t_bits();
    poke(18, 8'hA5);
    poke(17, 8'h00);
    for (int i = 0; i < 2; i++) begin
      run(mk(OP_BIT_TO_T, 5'h11, 3'(7 - i), .src(18)), CYC_BIT_OP);
      expF[FLAG_T] = 1'(1 - i);
      check(procFlags, expF);
      run(mk(OP_T_TO_BIT, 5'h11, 3'h2, .src(18)), CYC_BIT_OP);
      check(procFlags, expF);
      peek(17, (i == 0) ? 8'h04 : 8'h00);
    end
  endtask
  // Every single-flag write, on then off
  task automatic t_flags();
    int fl [3];
    fl = '{FLAG_H, FLAG_S, FLAG_V};
    for (int i = 0; i < 3; i++) begin
      for (int v = 1; v >= 0; v--) begin
        run(mk(OP_FLAG_WRITE, 5'h0, 3'(fl[i]), 1'(v)), CYC_BIT_OP);
        expF[fl[i]] = 1'(v);
        check(procFlags, expF);
      end
    end
  endtask
  // All pointers and modes; the pointer crosses a byte boundary
  task automatic t_indirect();
    logic [7:0] d;
    for (int w = 0; w < 2; w++) begin
      for (int s = 0; s < 3; s++) begin
        for (int m = 0; m < 3; m++) begin
          d = 8'(40 * w + 10 * s + m + 1);
          set_ptr(s, (m == 2) ? 16'h0100 : 16'h00FF);
          if (w == 0) begin
            cbm_mem_inst.dataMem[8'hFF] = d;
            run(mk(OP_READ_IND, 5'h8, .ps(s), .pm(m)), CYC_DATA);
            peek(8, d);
          end else begin
            poke(8, d);
            run(mk(OP_WRITE_IND, 5'h8, .ps(s), .pm(m)), CYC_DATA);
            check(at(8'hFF), d);
          end
          peek_ptr(s, (m == 1) ? 16'h0100 : 16'h00FF);
        end
      end
    end
  endtask
  // Largest displacement; pointer must stay put
  task automatic t_displaced();
    logic [7:0] d;
    for (int w = 0; w < 2; w++) begin
      for (int s = 1; s < 3; s++) begin
        d = 8'(16 * w + s + 144);
        set_ptr(s, 16'h0080);
        if (w == 0) begin
          cbm_mem_inst.dataMem[8'hBF] = d;
          run(mk(OP_READ_DISP, 5'h9, .ps(s), .q(6'h3F)), CYC_DATA);
          peek(9, d);
        end else begin
          poke(9, d);
          run(mk(OP_WRITE_DISP, 5'h9, .ps(s), .q(6'h3F)), CYC_DATA);
          check(at(8'hBF), d);
        end
        peek_ptr(s, 16'h0080);
      end
    end
  endtask
  // Direct copy between two addresses; flags untouched
  task automatic t_direct();
    cbm_mem_inst.dataMem[8'hFE] = 8'h5C;
    run(mk(OP_READ_DIR, 5'h3, .k(16'h00FE)), CYC_DATA);
    check(procFlags, expF);
    run(mk(OP_WRITE_DIR, 5'h3, .k(16'h00D0)), CYC_DATA);
    check(procFlags, expF);
    check(at(8'hD0), 8'h5C);
  endtask
  // Plain fetch keeps Z even with X named, post-increment form moves it
  task automatic t_fetch();
    cbm_mem_inst.progMem[8'h10] = 8'h5A;
    cbm_mem_inst.progMem[8'h11] = 8'hC3;
    set_ptr(2, 16'h0010);
    run(mk(OP_PROG_FETCH, 5'h0), CYC_PROG);
    peek(0, 8'h5A);
    run(mk(OP_PROG_FETCH, 5'h5, .ps(2), .pm(1)), CYC_PROG);
    peek(5, 8'h5A);
    peek_ptr(2, 16'h0011);
    run(mk(OP_PROG_FETCH, 5'h0, .ps(2)), CYC_PROG);
    peek(0, 8'hC3);
  endtask
  // Push then pop into another register
  task automatic t_stack();
    poke(16, 8'h6E);
    run(mk(OP_PUSH, 5'h14, .src(16)), CYC_DATA);
    check(at(SP_RESET[7:0]), 8'h6E);
    check(stackPtr[7:0], SP_RESET[7:0] - 8'h01);
    run(mk(OP_POP, 5'h14), CYC_DATA);
    check(stackPtr[7:0], SP_RESET[7:0]);
    check(procFlags, expF);
    peek(20, 8'h6E);
  endtask
  // Reset for 8 cycles, then the scenarios
  initial begin
    rst_b = 1'b0;
    cmdValid = 1'b0;
    cmd = '0;
    expF = FLAGS_RESET;
    miscompares = 0;
    checksDone = 0;
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    check(procFlags, FLAGS_RESET);
    check(stackPtr[15:8], SP_RESET[15:8]);
    t_rotate();
    t_bits();
    t_flags();
    t_indirect();
    t_displaced();
    t_direct();
    t_fetch();
    t_stack();
    end_of_test();
  end
endmodule // tb_top
